// File: inc/pfswc_pkg.sv
// Package: register map, field positions, reset values and timing for the flash self-write controller
package pfswc_pkg;
    // Register word offsets (byte addresses, one aligned word each)
    localparam logic [7:0] PFSWC_ADDR_LOW_OFS  = 8'h00;
    localparam logic [7:0] PFSWC_ADDR_HIGH_OFS = 8'h04;
    localparam logic [7:0] PFSWC_DATA_LOW_OFS  = 8'h08;
    localparam logic [7:0] PFSWC_DATA_HIGH_OFS = 8'h0c;
    localparam logic [7:0] PFSWC_CONTROL_OFS   = 8'h10;
    localparam logic [7:0] PFSWC_UNLOCK_OFS    = 8'h14;
    localparam logic [7:0] PFSWC_STATUS_OFS    = 8'h18;
    // Control register bit positions
    localparam int PFSWC_RD_BIT   = 0;
    localparam int PFSWC_WR_BIT   = 1;
    localparam int PFSWC_WRITE_ENABLE_BIT_BIT = 2;
    localparam int PFSWC_ERR_BIT  = 3;
    localparam int PFSWC_LATCH_ONLY_BIT = 5;
    localparam int PFSWC_FREE_BIT = 4;
    localparam int PFSWC_CONFIG_SPACE_SELECT_BIT = 6;
    // Status register bit positions
    localparam int PFSWC_STALL_BIT = 0;
    localparam int PFSWC_SLOT_BIT  = 1;
    // Unlock key bytes
    localparam logic [7:0] PFSWC_KEY1 = 8'h55;
    localparam logic [7:0] PFSWC_KEY2 = 8'haa;
    // Flash geometry
    localparam int PFSWC_WORD_W   = 14;
    localparam int PFSWC_ADDR_W   = 15;
    localparam int PFSWC_LATCH_N  = 32;
    localparam int PFSWC_LATCH_AW = 5;
    localparam logic [13:0] PFSWC_BLANK = 14'h3fff;
    // Forced idle slots after a start bit
    localparam logic [1:0] PFSWC_IDLE_SLOTS = 2'h2;
    // Erase/program time
    localparam int PFSWC_CLK_HZ  = 40_000_000;
    localparam int PFSWC_OP_MS   = 2;
    localparam int PFSWC_OP_CYC  = PFSWC_CLK_HZ / 1000 * PFSWC_OP_MS;
    // Controller states
    typedef enum logic [2:0] {
        PFSWC_IDLE  = 3'b000,
        PFSWC_RSLOT = 3'b001,
        PFSWC_WSLOT = 3'b010,
        PFSWC_BUSY  = 3'b011,
        PFSWC_DONE  = 3'b100
    } pfswc_state_t;
    // Operation kinds
    typedef enum logic [1:0] {
        PFSWC_OP_LOAD  = 2'b00,
        PFSWC_OP_PROG  = 2'b01,
        PFSWC_OP_ERASE = 2'b10
    } pfswc_op_t;
endpackage

// File: verilog/pfswc_unlock.sv
// Unlock key detector: 55h, AAh, then write-start, on consecutive accesses
`timescale 1ns/1ps
module pfswc_unlock
    import pfswc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       acc_i,
    input  wire logic       key_wr_i,
    input  wire logic [7:0] key_i,
    input  wire logic       start_i,
    input  wire logic       abort_i,
    output logic            armed_o
);
    typedef struct packed {
        logic [1:0] step;
    } pfswc_unl_t;

    pfswc_unl_t s_q;
    pfswc_unl_t s_d;

    // Any other access, or an abort, drops the partial key
    always_comb begin
        s_d = s_q;
        if (abort_i) begin
            s_d.step = 2'h0;
        end else if (acc_i) begin
            if (key_wr_i && key_i == PFSWC_KEY1) begin
                s_d.step = 2'h1;
            end else if (key_wr_i && key_i == PFSWC_KEY2 && s_q.step == 2'h1) begin
                s_d.step = 2'h2;
            end else begin
                s_d.step = 2'h0;
            end
        end
    end

    assign armed_o = (s_q.step == 2'h2) && start_i && !abort_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // pfswc_unlock

// File: verilog/pfswc_ctrl.sv
// Flash self-write controller: register slave, read slot, unlock, latches, erase/program
// Functional notes
// - Read takes the second instruction slot after read-start is set.
// - Read data lands in the data pair the next cycle.
// - Data pair holds value until next read or software write.
// - Erase, latch load, program happen only after an unbroken unlock.
// - Setting write-start forces two idle instruction slots.
// - Erase or program stalls the core about 2 ms, then continues.
// - Latch-only load forces two idle slots then no stall.
// - Erase is whole-row only, after erase-select, write-enable and unlock.
// - Core halts, clocks run; resumes third instruction after the write.
// - Programming never erases automatically.
// - Upper ten address bits select row, low five select latch.
// - One program writes at most 32 latch words.
// - Latches return to 3FFFh after every write or erase.
// - Latch-only set loads one latch; clear programs all latches.
// - Broken unlock starts neither latch load nor programming.
// - Start bits set-only by software, cleared by hardware at completion.
// - Erase and write need write-enable; it is clear after reset.
// - Unlock register is write-only and reads as zero.
// - Reset during a write sets the write-error flag.
//
// Chosen here: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
module pfswc_ctrl
    import pfswc_pkg::*;
#(
    parameter int OP_CYCLES = PFSWC_OP_CYC,
    parameter int LATCH_N   = PFSWC_LATCH_N
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Wishbone classic slave
    input  wire logic                    cyc_i,
    input  wire logic                    stb_i,
    input  wire logic                    we_i,
    input  wire logic [7:0]              adr_i,
    input  wire logic [3:0]              sel_i,
    input  wire logic [31:0]             dat_i,
    output logic      [31:0]             dat_o,
    output logic                         ack_o,
    // Core side
    input  wire logic                    irq_taken_i,
    output logic                         idle_slot_o,
    output logic                         stall_o,
    // Flash array port
    output logic                         fl_rd_o,
    output logic                         fl_erase_o,
    output logic                         fl_prog_o,
    output logic [PFSWC_ADDR_W-1:0]      fl_addr_o,
    output logic [LATCH_N*PFSWC_WORD_W-1:0] fl_wdata_o,
    input  wire logic [PFSWC_WORD_W-1:0] fl_rdata_i
);
    localparam int CNT_W = $clog2(OP_CYCLES + 1);

    typedef struct packed {
        pfswc_state_t       st;
        pfswc_op_t          op;
        logic [7:0]         adr_lo;
        logic [6:0]         adr_hi;
        logic [7:0]         dat_lo;
        logic [5:0]         dat_hi;
        logic               rd;
        logic               wr;
        logic               write_enable_bit;
        logic               err;
        logic               free;
        logic               latch_only;
        logic               config_space_select;
        logic [1:0]         slots;
        logic [CNT_W-1:0]   cnt;
        logic               ack;
        logic [31:0]        rdat;
        logic               fl_rd;
        logic               fl_erase;
        logic               fl_prog;
        logic               clr_latch;
        logic               skip;
    } pfswc_reg_t;

    pfswc_reg_t s_q;
    pfswc_reg_t s_d;

    // Latch bank sits outside the struct: it is memory, not control state
    logic [PFSWC_WORD_W-1:0] latch_q [LATCH_N];
    logic                    ld_latch;
    logic                    boot_q;

    logic                    req;
    logic                    wr_acc;
    logic                    ctl_wr;
    logic                    key_wr;
    logic                    start_set;
    logic                    armed;
    logic [PFSWC_ADDR_W-1:0] addr;
    logic [31:0]             ctl_word;

    // A new request is taken once; ack drops the cycle after it was given
    assign req    = cyc_i && stb_i && !s_q.ack;
    assign wr_acc = req && we_i && sel_i[0];
    assign ctl_wr = wr_acc && adr_i == PFSWC_CONTROL_OFS;
    assign key_wr = wr_acc && adr_i == PFSWC_UNLOCK_OFS;
    assign start_set = ctl_wr && dat_i[PFSWC_WR_BIT] && !s_q.wr && s_q.st == PFSWC_IDLE;
    assign addr   = {s_q.adr_hi, s_q.adr_lo};

    pfswc_unlock u_unlock (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .acc_i    (req),
        .key_wr_i (key_wr),
        .key_i    (dat_i[7:0]),
        .start_i  (start_set),
        .abort_i  (irq_taken_i),
        .armed_o  (armed)
    );

    assign ctl_word = {25'h0, s_q.config_space_select, s_q.latch_only, s_q.free, s_q.err, s_q.write_enable_bit, s_q.wr, s_q.rd};

    // Next-state: bus slave, sequencer and flash strobes
    always_comb begin
        s_d           = s_q;
        s_d.ack       = req;
        s_d.fl_rd     = 1'b0;
        s_d.fl_erase  = 1'b0;
        s_d.fl_prog   = 1'b0;
        s_d.clr_latch = 1'b0;
        ld_latch      = 1'b0;
        // Register reads; unmapped and unlock offsets answer zero
        if (req && !we_i) begin
            unique case (adr_i)
                PFSWC_ADDR_LOW_OFS:  s_d.rdat = {24'h0, s_q.adr_lo};
                PFSWC_ADDR_HIGH_OFS: s_d.rdat = {25'h0, s_q.adr_hi};
                PFSWC_DATA_LOW_OFS:  s_d.rdat = {24'h0, s_q.dat_lo};
                PFSWC_DATA_HIGH_OFS: s_d.rdat = {26'h0, s_q.dat_hi};
                PFSWC_CONTROL_OFS:   s_d.rdat = ctl_word;
                PFSWC_STATUS_OFS:    s_d.rdat = {30'h0, idle_slot_o, stall_o};
                default:             s_d.rdat = 32'h0;
            endcase
        end
        // Register writes (low byte lane carries the data)
        if (wr_acc) begin
            unique case (adr_i)
                PFSWC_ADDR_LOW_OFS:  s_d.adr_lo = dat_i[7:0];
                PFSWC_ADDR_HIGH_OFS: s_d.adr_hi = dat_i[6:0];
                PFSWC_DATA_LOW_OFS:  s_d.dat_lo = dat_i[7:0];
                PFSWC_DATA_HIGH_OFS: s_d.dat_hi = dat_i[5:0];
                PFSWC_CONTROL_OFS: begin
                    s_d.write_enable_bit = dat_i[PFSWC_WRITE_ENABLE_BIT_BIT];
                    s_d.free = dat_i[PFSWC_FREE_BIT];
                    s_d.latch_only = dat_i[PFSWC_LATCH_ONLY_BIT];
                    s_d.config_space_select = dat_i[PFSWC_CONFIG_SPACE_SELECT_BIT];
                    // Error flag only clears by software writing zero
                    s_d.err  = s_q.err & dat_i[PFSWC_ERR_BIT];
                    // Start bits: writing one sets, writing zero is ignored
                    if (dat_i[PFSWC_RD_BIT]) s_d.rd = 1'b1;
                end
                default: ;
            endcase
        end
        unique case (s_q.st)
            PFSWC_IDLE: begin
                if (ctl_wr && dat_i[PFSWC_RD_BIT] && !dat_i[PFSWC_CONFIG_SPACE_SELECT_BIT]) begin
                    // Read steals the second slot after read-start
                    s_d.st    = PFSWC_RSLOT;
                    s_d.slots = PFSWC_IDLE_SLOTS;
                end else if (start_set) begin
                    s_d.wr    = 1'b1;
                    s_d.slots = PFSWC_IDLE_SLOTS;
                    s_d.st    = PFSWC_WSLOT;
                    // Without a clean unlock and write-enable nothing happens,
                    // but the two forced idle slots still run
                    s_d.skip  = !armed || !dat_i[PFSWC_WRITE_ENABLE_BIT_BIT] || dat_i[PFSWC_CONFIG_SPACE_SELECT_BIT];
                    if (s_d.skip) begin
                        s_d.op = PFSWC_OP_LOAD;
                    end else if (dat_i[PFSWC_FREE_BIT]) begin
                        s_d.op = PFSWC_OP_ERASE;
                    end else if (dat_i[PFSWC_LATCH_ONLY_BIT]) begin
                        s_d.op = PFSWC_OP_LOAD;
                    end else begin
                        s_d.op = PFSWC_OP_PROG;
                    end
                end else if (s_q.rd) begin
                    s_d.rd = 1'b0;
                end
            end
            PFSWC_RSLOT: begin
                s_d.slots = s_q.slots - 2'h1;
                if (s_q.slots == PFSWC_IDLE_SLOTS) begin
                    s_d.fl_rd = 1'b1;
                end else begin
                    // Flash word captured into the data pair
                    s_d.dat_lo = fl_rdata_i[7:0];
                    s_d.dat_hi = fl_rdata_i[13:8];
                    s_d.rd     = 1'b0;
                    s_d.st     = PFSWC_IDLE;
                end
            end
            PFSWC_WSLOT: begin
                s_d.slots = s_q.slots - 2'h1;
                if (s_q.slots == 2'h1) begin
                    unique case (s_q.op)
                        PFSWC_OP_LOAD: begin
                            ld_latch = !s_q.skip;
                            s_d.st   = PFSWC_DONE;
                        end
                        PFSWC_OP_ERASE: begin
                            s_d.fl_erase = 1'b1;
                            s_d.cnt      = CNT_W'(OP_CYCLES);
                            s_d.st       = PFSWC_BUSY;
                        end
                        default: begin
                            // Final word goes into its latch as the row is written
                            ld_latch    = 1'b1;
                            s_d.fl_prog = 1'b1;
                            s_d.cnt     = CNT_W'(OP_CYCLES);
                            s_d.st      = PFSWC_BUSY;
                        end
                    endcase
                end
            end
            PFSWC_BUSY: begin
                // Core halted, clocks keep running; resume after the count
                s_d.cnt = s_q.cnt - CNT_W'(1);
                if (s_q.cnt == CNT_W'(1)) begin
                    s_d.clr_latch = 1'b1;
                    s_d.st        = PFSWC_DONE;
                end
            end
            PFSWC_DONE: begin
                s_d.wr = 1'b0;
                s_d.st = PFSWC_IDLE;
            end
            default: s_d.st = PFSWC_IDLE;
        endcase
    end

    // Idle slots while a start is pending; stall through the operation
    assign idle_slot_o = s_q.st == PFSWC_RSLOT || s_q.st == PFSWC_WSLOT;
    assign stall_o     = s_q.st == PFSWC_BUSY;
    assign dat_o       = s_q.rdat;
    assign ack_o       = s_q.ack;
    assign fl_rd_o     = s_q.fl_rd;
    assign fl_erase_o  = s_q.fl_erase;
    assign fl_prog_o   = s_q.fl_prog;
    // Erase targets the whole row: latch index bits forced to zero
    assign fl_addr_o   = s_q.fl_erase ? {addr[14:5], 5'h0} : addr;

    genvar gi;
    generate
        for (gi = 0; gi < LATCH_N; gi++) begin : g_lat
            assign fl_wdata_o[gi*PFSWC_WORD_W +: PFSWC_WORD_W] = latch_q[gi];
        end
    endgenerate

    // Control state register; error flag survives reset taken mid-write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q      <= '0;
            s_q.st   <= PFSWC_IDLE;
            s_q.op   <= PFSWC_OP_LOAD;
            s_q.err  <= (s_q.st == PFSWC_WSLOT || s_q.st == PFSWC_BUSY) | s_q.err;
            s_q.write_enable_bit <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // Latch bank: blank on reset and after every erase or program
    always_ff @(posedge clk_i) begin
        boot_q <= rst_i;
        for (int i = 0; i < LATCH_N; i++) begin
            if (boot_q || s_q.clr_latch) begin
                latch_q[i] <= PFSWC_BLANK;
            end else if (ld_latch && addr[PFSWC_LATCH_AW-1:0] == PFSWC_LATCH_AW'(i)) begin
                latch_q[i] <= {s_q.dat_hi, s_q.dat_lo};
            end
        end
    end
endmodule // pfswc_ctrl

// File: tb/pfswc_ctrl_checker.sv
// Checker: port-level timing relations of the flash self-write controller
`timescale 1ns/1ps
module pfswc_ctrl_checker
    import pfswc_pkg::*;
#(
    parameter int OP_CYCLES = PFSWC_OP_CYC,
    parameter int LATCH_N   = PFSWC_LATCH_N
) (
    input wire logic                          clk_i,
    input wire logic                          rst_i,
    input wire logic                          cyc_i,
    input wire logic                          stb_i,
    input wire logic                          we_i,
    input wire logic [7:0]                    adr_i,
    input wire logic [3:0]                    sel_i,
    input wire logic [31:0]                   dat_i,
    input wire logic [31:0]                   dat_o,
    input wire logic                          ack_o,
    input wire logic                          irq_taken_i,
    input wire logic                          idle_slot_o,
    input wire logic                          stall_o,
    input wire logic                          fl_rd_o,
    input wire logic                          fl_erase_o,
    input wire logic                          fl_prog_o,
    input wire logic [PFSWC_ADDR_W-1:0]       fl_addr_o,
    input wire logic [LATCH_N*PFSWC_WORD_W-1:0] fl_wdata_o,
    input wire logic [PFSWC_WORD_W-1:0]       fl_rdata_i
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Stall length counter; a counter avoids unrolling a long repetition
    int unsigned stall_n_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) stall_n_q <= 0;
        else stall_n_q <= stall_o ? stall_n_q + 1 : 0;
    end
    sequence s_two_slots; idle_slot_o [*2] ##1 !idle_slot_o; endsequence
    property p_ack_take; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    property p_ack_one; ack_o |=> !ack_o; endproperty
    property p_rd_pulse; fl_rd_o |=> !fl_rd_o; endproperty
    property p_idle_two; $rose(idle_slot_o) |-> s_two_slots; endproperty
    property p_stall_len; $fell(stall_o) |-> stall_n_q == OP_CYCLES; endproperty
    property p_stall_max; stall_o |-> stall_n_q < OP_CYCLES; endproperty
    property p_pulse_stall; fl_erase_o || fl_prog_o |-> ##[0:1] stall_o; endproperty
    property p_erase_row; fl_erase_o |-> fl_addr_o[4:0] == 5'h00; endproperty
    property p_no_auto; fl_prog_o |-> !fl_erase_o; endproperty
    property p_blank;
        $fell(stall_o) |-> ##[0:1] (fl_wdata_o == {LATCH_N{PFSWC_BLANK}});
    endproperty
    property p_halt; stall_o |-> !idle_slot_o; endproperty
    a_ack_take: assert property (p_ack_take) else $error("ack not given");
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe long");
    a_idle_two: assert property (p_idle_two) else $error("idle slots not two");
    a_stall_len: assert property (p_stall_len) else $error("stall length off");
    a_stall_max: assert property (p_stall_max) else $error("stall overrun");
    a_pulse_stall: assert property (p_pulse_stall) else $error("no stall");
    a_erase_row: assert property (p_erase_row) else $error("erase not row");
    a_no_auto: assert property (p_no_auto) else $error("erase with program");
    a_blank: assert property (p_blank) else $error("latches not blank");
    a_halt: assert property (p_halt) else $error("slot during stall");
endmodule // pfswc_ctrl_checker

bind pfswc_ctrl pfswc_ctrl_checker #(.OP_CYCLES(OP_CYCLES), .LATCH_N(LATCH_N))
    i_pfswc_ctrl_checker (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .irq_taken_i(irq_taken_i), .idle_slot_o(idle_slot_o), .stall_o(stall_o),
    .fl_rd_o(fl_rd_o), .fl_erase_o(fl_erase_o), .fl_prog_o(fl_prog_o),
    .fl_addr_o(fl_addr_o), .fl_wdata_o(fl_wdata_o), .fl_rdata_i(fl_rdata_i));

// File: tb/pfswc_flash_model.sv
// Behavioural flash array behind the controller's flash port
`timescale 1ns/1ps
module pfswc_flash_model
    import pfswc_pkg::*;
#(
    parameter int LATCH_N = PFSWC_LATCH_N
) (
    input wire logic                            clk_i,
    input wire logic                            rd_i,
    input wire logic                            erase_i,
    input wire logic                            prog_i,
    input wire logic [PFSWC_ADDR_W-1:0]         addr_i,
    input wire logic [LATCH_N*PFSWC_WORD_W-1:0] wdata_i,
    output logic     [PFSWC_WORD_W-1:0]         rdata_o
);
    logic [13:0] mem [0:32767];
    logic [13:0] churn_q = 14'h0000;
    initial begin
        for (int i = 0; i < 32768; i++) mem[i] = PFSWC_BLANK;
    end
    // Word stands while the read strobe stands; otherwise the data churns
    assign rdata_o = rd_i ? mem[addr_i] : churn_q;
    always @(posedge clk_i) begin
        churn_q <= ~churn_q;
        if (erase_i) begin
            for (int i = 0; i < 32; i++) mem[{addr_i[14:5], 5'(i)}] = PFSWC_BLANK;
        end
        // Programming only clears bits; nothing erases here
        if (prog_i) begin
            for (int i = 0; i < LATCH_N; i++) begin
                mem[{addr_i[14:5], 5'(i)}] &= wdata_i[14*i +: 14];
            end
        end
    end
endmodule // pfswc_flash_model

// File: tb/tb_top.sv
// Self-checking bench for the flash self-write controller
`timescale 1ns/1ps
module tb_top;
    import pfswc_pkg::*;
    localparam logic [7:0] ALO = PFSWC_ADDR_LOW_OFS;
    localparam logic [7:0] AHI = PFSWC_ADDR_HIGH_OFS;
    localparam logic [7:0] DLO = PFSWC_DATA_LOW_OFS;
    localparam logic [7:0] DHI = PFSWC_DATA_HIGH_OFS;
    localparam logic [7:0] CTL = PFSWC_CONTROL_OFS;
    localparam logic [7:0] UNL = PFSWC_UNLOCK_OFS;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, irq = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h1;
    logic [31:0] dat = 32'h0, rdat, exp_w;
    logic ack, idle, stall, frd, fer, fpr;
    logic [14:0] fadr, b;
    logic [447:0] fwd;
    logic [13:0] frdata, v, v0, v1, v2;
    logic [15:0] lf = 16'h4318;
    logic [31:0] eq [$];
    int failures = 0, comparisons = 0, ticks = 0;

    pfswc_ctrl #(.OP_CYCLES(20)) i_pfswc_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(rdat),
        .ack_o(ack), .irq_taken_i(irq), .idle_slot_o(idle), .stall_o(stall), .fl_rd_o(frd),
        .fl_erase_o(fer), .fl_prog_o(fpr), .fl_addr_o(fadr), .fl_wdata_o(fwd),
        .fl_rdata_i(frdata));
    pfswc_flash_model i_pfswc_flash_model (.clk_i(clk_i), .rd_i(frd), .erase_i(fer),
        .prog_i(fpr), .addr_i(fadr), .wdata_i(fwd), .rdata_o(frdata));

    always #12.5 clk_i = ~clk_i;

    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic results;
        $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // One classic cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        eq.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask

    // Control write, then slots and any stall run out
    task automatic go(input logic [7:0] c);
        wb(1'b1, CTL, {24'h0, c});
        repeat (4) @(posedge clk_i);
        while (stall === 1'b1) @(posedge clk_i);
    endtask

    task automatic key(input logic [7:0] c);
        wb(1'b1, UNL, {24'h0, PFSWC_KEY1});
        wb(1'b1, UNL, {24'h0, PFSWC_KEY2});
        go(c);
    endtask

    task automatic prep(input logic [4:0] i, input logic [13:0] d);
        wb(1'b1, DLO, {24'h0, d[7:0]});
        wb(1'b1, DHI, {26'h0, d[13:8]});
        wb(1'b1, ALO, {24'h0, b[7:5], i});
    endtask

    task automatic fread(input logic [14:0] a, input logic [13:0] d);
        wb(1'b1, ALO, {24'h0, a[7:0]});
        wb(1'b1, AHI, {25'h0, a[14:8]});
        go(8'h01);
        rd(DLO, {24'h0, d[7:0]});
        rd(DHI, {26'h0, d[13:8]});
    endtask

    // Each read answer is matched with the oldest note
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0) begin
            exp_w = eq.pop_front();
            comparisons++;
            if (rdat !== exp_w) begin
                failures++;
                $display("Error dat_o expected %h seen %h", exp_w, rdat);
            end
        end
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 20000) begin
            failures++;
            results();
        end
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(UNL, 32'h0);
        rd(8'h1c, 32'h0);
        $display("Test register map done");
        lf = nx(lf);
        b = {lf[9:0], 5'h00};
        lf = nx(lf);
        v = lf[13:0];
        i_pfswc_flash_model.mem[b ^ 15'h4000] = v;
        fread(b ^ 15'h4000, v);
        wb(1'b1, ALO, 32'h0);
        rd(DLO, {24'h0, v[7:0]});
        wb(1'b1, DLO, 32'h5a);
        rd(DLO, 32'h5a);
        $display("Test read done");
        wb(1'b1, AHI, {25'h0, b[14:8]});
        wb(1'b1, CTL, 32'h24);
        lf = nx(lf);
        v0 = lf[13:0];
        prep(5'd0, v0);
        key(8'h26);
        lf = nx(lf);
        v1 = lf[13:0];
        prep(5'd31, v1);
        key(8'h26);
        // Broken unlocks: an access between keys, then an interrupt
        prep(5'd5, v0);
        wb(1'b1, UNL, 32'h55);
        rd(8'h1c, 32'h0);
        wb(1'b1, UNL, 32'haa);
        go(8'h26);
        wb(1'b1, UNL, 32'h55);
        irq <= 1'b1;
        wb(1'b1, UNL, 32'haa);
        irq <= 1'b0;
        go(8'h26);
        lf = nx(lf);
        v2 = lf[13:0];
        wb(1'b1, CTL, 32'h04);
        prep(5'd1, v2);
        key(8'h06);
        fread(b, v0);
        fread(b | 15'd31, v1);
        fread(b | 15'd1, v2);
        fread(b | 15'd5, PFSWC_BLANK);
        $display("Test program done");
        wb(1'b1, CTL, 32'h10);
        wb(1'b1, ALO, {24'h0, b[7:5], 5'd9});
        key(8'h12);
        fread(b, v0);
        wb(1'b1, CTL, 32'h14);
        wb(1'b1, ALO, {24'h0, b[7:5], 5'd9});
        key(8'h16);
        fread(b, PFSWC_BLANK);
        fread(b | 15'd31, PFSWC_BLANK);
        $display("Test erase done");
        wb(1'b1, CTL, 32'h14);
        wb(1'b1, UNL, 32'h55);
        wb(1'b1, UNL, 32'haa);
        wb(1'b1, CTL, 32'h16);
        while (stall !== 1'b1) @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(CTL, 32'h08);
        wb(1'b1, CTL, 32'h0);
        rd(CTL, 32'h0);
        $display("Test reset in erase done");
        repeat (4) @(posedge clk_i);
        results();
    end
endmodule // tb_top
